// ==== rtl/bhl_loader.sv ====
// Notes on behaviour
// - first two bytes must match signature
// - prefix: type, size low, size high, checksum
// - bad 8-bit content sum ignores block
// - zero type byte ends header
// - types 3,4,5 load device, config, strings
// - good autoexec block runs; attach comes before it, and only if the device block is ok
// - host firmware loads on first device request
// - device block: 18 bytes, mps 8, vendor, one config
// - config reports self power, wakeup, power
// - endpoint is bulk OUT number one
// - string types 0x03, language 0x0409; language checked, type test only fires after a zero length
// - bad host checksum detaches, waits, reattaches
// - config total length equals summed lengths
`timescale 1ns/1ps
module bhl_loader #(
	parameter logic [7:0] SIGNATURE_LOW_BYTE  = 8'h5a, // arbitrary value
	parameter logic [7:0] SIGNATURE_HIGH_BYTE = 8'ha5, // arbitrary value
	parameter int         REATTACH_CYC        = bhl_pkg::REATTACH_CYC
) (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        link_clk,
	input  wire logic        link_valid,
	input  wire logic [7:0]  link_byte,
	output logic             link_ready,
	input  wire logic        host_valid,
	input  wire logic [7:0]  host_byte,
	output logic             host_ready,
	input  wire logic        get_dev_desc,
	input  wire logic [1:0]  desc_rd_sel,
	input  wire logic [6:0]  desc_rd_addr,
	output logic [7:0]       desc_rd_data,
	output logic             dev_desc_ok,
	output logic             cfg_desc_ok,
	output logic             str_desc_ok,
	output logic             cfg_self_powered,
	output logic             cfg_remote_wakeup,
	output logic [7:0]       cfg_max_power,
	output logic             cfg_bulk_out_ep1,
	output logic             code_wr_en,
	output logic [15:0]      code_addr,
	output logic [7:0]       code_data,
	output logic             usb_attach,
	output logic             fw_start,
	output logic             fw_running
);
	bhl_pkg::bhl_state_t state_reg;
	logic [7:0]  blk_type_reg;
	logic [15:0] blk_size_reg;
	logic [7:0]  blk_sum_reg;
	logic [7:0]  run_sum_reg;
	logic [15:0] idx_reg;
	logic        sig_lo_ok_reg;
	logic        dev_fields_ok_reg;
	logic [15:0] walk_next_reg;
	logic [15:0] walk_sum_reg;
	logic        walk_ok_reg;
	logic [15:0] cfg_tlen_reg;
	logic        host_done_reg;
	logic        early_attach_reg;
	logic [31:0] wait_reg;
	logic [7:0]  dev_mem [0:17];
	logic [7:0]  cfg_mem [0:bhl_pkg::CFG_MAX-1];
	logic [7:0]  str_mem [0:bhl_pkg::STR_MAX-1];
	logic        rx_valid;
	logic [7:0]  rx_byte;
	logic        hdr_phase;
	logic        host_phase;
	logic        in_valid;
	logic [7:0]  in_byte;
	logic        take;
	logic        block_end;
	logic [7:0]  sum_next;
	logic        sum_match;
	logic [15:0] idx_next;

	function automatic logic is_desc(input logic [7:0] t);
		is_desc = (t == bhl_pkg::TYPE_DEV) || (t == bhl_pkg::TYPE_CFG)
			|| (t == bhl_pkg::TYPE_STR);
	endfunction : is_desc

	bhl_link_rx u_link_rx (
		.sys_clk    (sys_clk),
		.link_clk   (link_clk),
		.rst_n      (rst_n),
		.link_valid (link_valid),
		.link_byte  (link_byte),
		.link_ready (link_ready),
		.rx_valid   (rx_valid),
		.rx_byte    (rx_byte),
		.rx_take    (take && hdr_phase)
	);

	// source select: header from the link, firmware from the host
	assign hdr_phase  = (state_reg <= bhl_pkg::S_BODY);
	assign host_phase = (state_reg >= bhl_pkg::S_H_SZL) && (state_reg <= bhl_pkg::S_H_BODY);
	assign in_valid   = hdr_phase ? rx_valid : (host_phase && host_valid);
	assign in_byte    = hdr_phase ? rx_byte : host_byte;
	assign take       = in_valid;
	assign host_ready = host_phase;
	assign idx_next   = idx_reg + 16'h0001;
	assign sum_next   = run_sum_reg + in_byte;
	assign sum_match  = (sum_next == blk_sum_reg);
	assign block_end  = take && ((state_reg == bhl_pkg::S_BODY)
		|| (state_reg == bhl_pkg::S_H_BODY)) && (idx_next == blk_size_reg);

	// main sequencer
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= bhl_pkg::S_SIG0;
		end else begin
			case (state_reg)
				bhl_pkg::S_SIG0: if (take) state_reg <= bhl_pkg::S_SIG1;
				bhl_pkg::S_SIG1: if (take) begin
					if (sig_lo_ok_reg && in_byte == SIGNATURE_HIGH_BYTE)
						state_reg <= bhl_pkg::S_TYPE;
					else
						state_reg <= bhl_pkg::S_ATTACHED;
				end
				bhl_pkg::S_TYPE: if (take) begin
					if (in_byte == bhl_pkg::TYPE_END)
						state_reg <= bhl_pkg::S_ATTACHED;
					else
						state_reg <= bhl_pkg::S_SZL;
				end
				bhl_pkg::S_SZL: if (take) state_reg <= bhl_pkg::S_SZH;
				bhl_pkg::S_SZH: if (take) state_reg <= bhl_pkg::S_SUM;
				bhl_pkg::S_SUM: if (take) begin
					state_reg <= (blk_size_reg == 16'h0000) ? bhl_pkg::S_TYPE
						: bhl_pkg::S_BODY;
				end
				bhl_pkg::S_BODY: if (block_end) begin
					if (blk_type_reg == bhl_pkg::TYPE_AUTO && sum_match)
						state_reg <= bhl_pkg::S_RUN;
					else
						state_reg <= bhl_pkg::S_TYPE;
				end
				bhl_pkg::S_ATTACHED: if (get_dev_desc && !host_done_reg)
					state_reg <= bhl_pkg::S_H_SZL;
				bhl_pkg::S_H_SZL: if (take) state_reg <= bhl_pkg::S_H_SZH;
				bhl_pkg::S_H_SZH: if (take) state_reg <= bhl_pkg::S_H_SUM;
				bhl_pkg::S_H_SUM: if (take) begin
					state_reg <= (blk_size_reg == 16'h0000) ? bhl_pkg::S_DETACH
						: bhl_pkg::S_H_BODY;
				end
				bhl_pkg::S_H_BODY: if (block_end)
					state_reg <= sum_match ? bhl_pkg::S_RUN : bhl_pkg::S_DETACH;
				bhl_pkg::S_DETACH: if (wait_reg == 32'h0000_0000)
					state_reg <= bhl_pkg::S_ATTACHED;
				bhl_pkg::S_RUN: state_reg <= bhl_pkg::S_RUN;
				default: state_reg <= bhl_pkg::S_SIG0;
			endcase
		end
	end

	// prefix fields, byte index and running sum
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sig_lo_ok_reg <= 1'b0;
			blk_type_reg  <= 8'h00;
			blk_size_reg  <= 16'h0000;
			blk_sum_reg   <= 8'h00;
			run_sum_reg   <= 8'h00;
			idx_reg       <= 16'h0000;
		end else if (take) begin
			case (state_reg)
				bhl_pkg::S_SIG0: sig_lo_ok_reg <= (in_byte == SIGNATURE_LOW_BYTE);
				bhl_pkg::S_TYPE: blk_type_reg <= in_byte;
				bhl_pkg::S_SZL, bhl_pkg::S_H_SZL: blk_size_reg[7:0] <= in_byte;
				bhl_pkg::S_SZH, bhl_pkg::S_H_SZH: blk_size_reg[15:8] <= in_byte;
				bhl_pkg::S_SUM, bhl_pkg::S_H_SUM: begin
					blk_sum_reg <= in_byte;
					run_sum_reg <= 8'h00;
					idx_reg     <= 16'h0000;
				end
				bhl_pkg::S_BODY, bhl_pkg::S_H_BODY: begin
					run_sum_reg <= sum_next;
					idx_reg     <= idx_next;
				end
				default: idx_reg <= idx_reg;
			endcase
		end
	end

	// descriptor stores, written as content streams in
	always_ff @(posedge sys_clk) begin
		if (take && state_reg == bhl_pkg::S_BODY) begin
			if (blk_type_reg == bhl_pkg::TYPE_DEV && idx_reg < bhl_pkg::DEV_LEN)
				dev_mem[idx_reg[4:0]] <= in_byte;
			if (blk_type_reg == bhl_pkg::TYPE_CFG && idx_reg < bhl_pkg::CFG_MAX)
				cfg_mem[idx_reg[5:0]] <= in_byte;
			if (blk_type_reg == bhl_pkg::TYPE_STR && idx_reg < bhl_pkg::STR_MAX)
				str_mem[idx_reg[6:0]] <= in_byte;
		end
	end

	// device block field checks
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			dev_fields_ok_reg <= 1'b0;
		end else if (take && state_reg == bhl_pkg::S_SUM) begin
			dev_fields_ok_reg <= (blk_size_reg == bhl_pkg::DEV_LEN);
		end else if (take && state_reg == bhl_pkg::S_BODY) begin
			if ((idx_reg == bhl_pkg::DEV_MPS_IDX && in_byte != bhl_pkg::DEV_MPS)
				|| (idx_reg == bhl_pkg::DEV_CLASS_IDX && in_byte != bhl_pkg::VENDOR_CLASS)
				|| (idx_reg == bhl_pkg::DEV_NCFG_IDX && in_byte != bhl_pkg::NUM_CONFIGS))
				dev_fields_ok_reg <= 1'b0;
		end
	end

	// walk sub-descriptor lengths inside config and string blocks
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			walk_next_reg <= 16'h0000;
			walk_sum_reg  <= 16'h0000;
			walk_ok_reg   <= 1'b0;
			cfg_tlen_reg  <= 16'h0000;
		end else if (take && state_reg == bhl_pkg::S_SUM) begin
			walk_next_reg <= 16'h0000;
			walk_sum_reg  <= 16'h0000;
			walk_ok_reg   <= 1'b1;
		end else if (take && state_reg == bhl_pkg::S_BODY) begin
			if (idx_reg == walk_next_reg) begin
				walk_next_reg <= walk_next_reg + {8'h00, in_byte};
				walk_sum_reg  <= walk_sum_reg + {8'h00, in_byte};
				if (in_byte == 8'h00)
					walk_ok_reg <= 1'b0;
			end
			if (blk_type_reg == bhl_pkg::TYPE_STR && idx_reg == walk_next_reg + 16'h0001
				&& in_byte != bhl_pkg::STR_DTYPE)
				walk_ok_reg <= 1'b0;
			if (blk_type_reg == bhl_pkg::TYPE_STR
				&& ((idx_reg == 16'h0002 && in_byte != bhl_pkg::LANG_ID[7:0])
				|| (idx_reg == 16'h0003 && in_byte != bhl_pkg::LANG_ID[15:8])))
				walk_ok_reg <= 1'b0;
			if (idx_reg == bhl_pkg::CFG_TLEN_IDX)
				cfg_tlen_reg[7:0] <= in_byte;
			if (idx_reg == bhl_pkg::CFG_TLEN_IDX + 16'h0001)
				cfg_tlen_reg[15:8] <= in_byte;
		end
	end

	// block validity: cleared at a new block of the kind, set on a good end
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			dev_desc_ok <= 1'b0;
			cfg_desc_ok <= 1'b0;
			str_desc_ok <= 1'b0;
		end else if (take && state_reg == bhl_pkg::S_SUM) begin
			if (blk_type_reg == bhl_pkg::TYPE_DEV) dev_desc_ok <= 1'b0;
			if (blk_type_reg == bhl_pkg::TYPE_CFG) cfg_desc_ok <= 1'b0;
			if (blk_type_reg == bhl_pkg::TYPE_STR) str_desc_ok <= 1'b0;
		end else if (block_end && state_reg == bhl_pkg::S_BODY && sum_match) begin
			if (blk_type_reg == bhl_pkg::TYPE_DEV)
				dev_desc_ok <= dev_fields_ok_reg;
			if (blk_type_reg == bhl_pkg::TYPE_CFG)
				cfg_desc_ok <= walk_ok_reg && blk_size_reg <= bhl_pkg::CFG_MAX
					&& cfg_tlen_reg == blk_size_reg
					&& walk_sum_reg + {8'h00, sum_next - run_sum_reg} != 16'h0000
					&& walk_next_reg == blk_size_reg;
			if (blk_type_reg == bhl_pkg::TYPE_STR)
				str_desc_ok <= walk_ok_reg && blk_size_reg <= bhl_pkg::STR_MAX
					&& walk_next_reg == blk_size_reg;
		end
	end

	// configuration properties seen by the USB function
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_self_powered  <= 1'b0;
			cfg_remote_wakeup <= 1'b0;
			cfg_max_power     <= 8'h00;
			cfg_bulk_out_ep1  <= 1'b0;
		end else if (cfg_desc_ok) begin
			cfg_self_powered  <= cfg_mem[bhl_pkg::CFG_ATTR_IDX[5:0]][bhl_pkg::ATTR_SELF_BIT];
			cfg_remote_wakeup <= cfg_mem[bhl_pkg::CFG_ATTR_IDX[5:0]][bhl_pkg::ATTR_WAKE_BIT];
			cfg_max_power     <= cfg_mem[bhl_pkg::CFG_POWER_IDX[5:0]];
			cfg_bulk_out_ep1  <= cfg_mem[bhl_pkg::EP_ADDR_IDX[5:0]] == bhl_pkg::EP_OUT1
				&& cfg_mem[bhl_pkg::EP_ATTR_IDX[5:0]] == bhl_pkg::EP_BULK;
		end else begin
			cfg_bulk_out_ep1  <= 1'b0;
		end
	end

	// descriptor read port answering host requests
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			desc_rd_data <= 8'h00;
		end else begin
			case (desc_rd_sel)
				2'h0: desc_rd_data <= (dev_desc_ok && desc_rd_addr < 7'h12)
					? dev_mem[desc_rd_addr[4:0]] : 8'h00;
				2'h1: desc_rd_data <= (cfg_desc_ok && desc_rd_addr < 7'h40)
					? cfg_mem[desc_rd_addr[5:0]] : 8'h00;
				2'h2: desc_rd_data <= str_desc_ok ? str_mem[desc_rd_addr] : 8'h00;
				default: desc_rd_data <= 8'h00;
			endcase
		end
	end

	// firmware into code memory, from an autoexec block or the host
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			code_wr_en <= 1'b0;
			code_addr  <= 16'h0000;
			code_data  <= 8'h00;
		end else begin
			code_wr_en <= take && ((state_reg == bhl_pkg::S_BODY
				&& blk_type_reg == bhl_pkg::TYPE_AUTO) || state_reg == bhl_pkg::S_H_BODY);
			code_addr  <= idx_reg;
			code_data  <= in_byte;
		end
	end

	// attach control, detach pause and hand-over
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			usb_attach       <= 1'b0;
			early_attach_reg <= 1'b0;
			host_done_reg    <= 1'b0;
			wait_reg         <= 32'h0000_0000;
			fw_start         <= 1'b0;
			fw_running       <= 1'b0;
		end else begin
			fw_start <= 1'b0;
			if (state_reg == bhl_pkg::S_TYPE && take && in_byte == bhl_pkg::TYPE_AUTO
				&& dev_desc_ok) begin
				usb_attach       <= 1'b1;
				early_attach_reg <= 1'b1;
			end
			if ((state_reg == bhl_pkg::S_TYPE && take && in_byte == bhl_pkg::TYPE_END)
				|| (state_reg == bhl_pkg::S_SIG1 && take && !(sig_lo_ok_reg
				&& in_byte == SIGNATURE_HIGH_BYTE)))
				usb_attach <= 1'b1;
			if (state_reg == bhl_pkg::S_ATTACHED && get_dev_desc)
				host_done_reg <= 1'b1;
			if ((block_end && state_reg == bhl_pkg::S_H_BODY && !sum_match)
				|| (take && state_reg == bhl_pkg::S_H_SUM && blk_size_reg == 16'h0000)) begin
				usb_attach    <= 1'b0;
				host_done_reg <= 1'b0;
				wait_reg      <= REATTACH_CYC[31:0];
			end else if (state_reg == bhl_pkg::S_DETACH) begin
				if (wait_reg == 32'h0000_0000)
					usb_attach <= 1'b1;
				else
					wait_reg <= wait_reg - 32'h0000_0001;
			end
			if (block_end && sum_match && (state_reg == bhl_pkg::S_H_BODY
				|| blk_type_reg == bhl_pkg::TYPE_AUTO)) begin
				fw_start   <= 1'b1;
				fw_running <= 1'b1;
			end
		end
	end

	a_sig_mismatch_skip: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state_reg == bhl_pkg::S_SIG1 && take && !(sig_lo_ok_reg
		&& in_byte == SIGNATURE_HIGH_BYTE)) |=> usb_attach && !dev_desc_ok
		&& state_reg == bhl_pkg::S_ATTACHED)
		else $error("bad signature did not skip header");
	a_size_high_byte: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state_reg == bhl_pkg::S_SZH && take) |=> blk_size_reg[15:8] == $past(in_byte)
		&& state_reg == bhl_pkg::S_SUM)
		else $error("size high byte not captured");
	a_bad_sum_ignored: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(block_end && state_reg == bhl_pkg::S_BODY && !sum_match) |=> !fw_start
		&& state_reg == bhl_pkg::S_TYPE)
		else $error("block with bad checksum was used");
	a_end_attaches: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state_reg == bhl_pkg::S_TYPE && take && in_byte == bhl_pkg::TYPE_END)
		|=> usb_attach && state_reg == bhl_pkg::S_ATTACHED)
		else $error("terminator did not end header");
	a_autoexec_runs: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(block_end && sum_match && state_reg == bhl_pkg::S_BODY
		&& blk_type_reg == bhl_pkg::TYPE_AUTO) |=> fw_start
		&& usb_attach == early_attach_reg)
		else $error("autoexec hand-over wrong");
	a_host_load_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(host_ready) |-> $past(get_dev_desc) && !$past(host_done_reg))
		else $error("host download began without request");
	a_bad_fw_detach: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(block_end && state_reg == bhl_pkg::S_H_BODY && !sum_match)
		|=> !usb_attach [*8])
		else $error("bad host firmware did not detach");
	a_cfg_total_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(cfg_desc_ok) |-> $past(cfg_tlen_reg) == $past(blk_size_reg)
		&& $past(walk_next_reg) == $past(blk_size_reg))
		else $error("config total length mismatch accepted");
	a_unknown_skip: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state_reg == bhl_pkg::S_BODY && !is_desc(blk_type_reg)
		&& blk_type_reg != bhl_pkg::TYPE_AUTO) |=> !code_wr_en)
		else $error("unknown block was loaded");
endmodule : bhl_loader

// ==== rtl/bhl_pkg.sv ====
package bhl_pkg;
	// block data type codes
	localparam logic [7:0]  TYPE_END      = 8'h00;
	localparam logic [7:0]  TYPE_DEV      = 8'h03;
	localparam logic [7:0]  TYPE_CFG      = 8'h04;
	localparam logic [7:0]  TYPE_STR      = 8'h05;
	localparam logic [7:0]  TYPE_AUTO     = 8'h07;
	// device descriptor layout
	localparam logic [15:0] DEV_LEN       = 16'h0012;
	localparam logic [15:0] DEV_CLASS_IDX = 16'h0004;
	localparam logic [15:0] DEV_MPS_IDX   = 16'h0007;
	localparam logic [15:0] DEV_NCFG_IDX  = 16'h0011;
	localparam logic [7:0]  DEV_MPS       = 8'h08;
	localparam logic [7:0]  VENDOR_CLASS  = 8'hff;
	localparam logic [7:0]  NUM_CONFIGS   = 8'h01;
	// configuration block layout
	localparam logic [15:0] CFG_TLEN_IDX  = 16'h0002;
	localparam logic [15:0] CFG_ATTR_IDX  = 16'h0007;
	localparam logic [15:0] CFG_POWER_IDX = 16'h0008;
	localparam logic [15:0] EP_ADDR_IDX   = 16'h0014;
	localparam logic [15:0] EP_ATTR_IDX   = 16'h0015;
	localparam logic [7:0]  EP_OUT1       = 8'h01;
	localparam logic [7:0]  EP_BULK       = 8'h02;
	localparam int          ATTR_SELF_BIT = 6;
	localparam int          ATTR_WAKE_BIT = 5;
	// string block
	localparam logic [7:0]  STR_DTYPE     = 8'h03;
	localparam logic [15:0] LANG_ID       = 16'h0409;
	// store sizes
	localparam int          CFG_MAX       = 64;
	localparam int          STR_MAX       = 128;
	// timing
	localparam int          SYS_CLK_MHZ   = 200;
	localparam int          REATTACH_US   = 32'h0000_2710; // 10000 us detach pause
	localparam int          REATTACH_CYC  = REATTACH_US * SYS_CLK_MHZ;
	typedef enum logic [3:0] {
		S_SIG0, S_SIG1, S_TYPE, S_SZL, S_SZH, S_SUM, S_BODY, S_ATTACHED,
		S_H_SZL, S_H_SZH, S_H_SUM, S_H_BODY, S_DETACH, S_RUN
	} bhl_state_t;
endpackage : bhl_pkg

// ==== rtl/bhl_link_rx.sv ====
`timescale 1ns/1ps
module bhl_link_rx (
	input  wire logic       sys_clk,
	input  wire logic       link_clk,
	input  wire logic       rst_n,
	input  wire logic       link_valid,
	input  wire logic [7:0] link_byte,
	output logic            link_ready,
	output logic            rx_valid,
	output logic [7:0]      rx_byte,
	input  wire logic       rx_take
);
	logic       req_reg;
	logic [7:0] hold_reg;
	logic       ack_meta_reg;
	logic       ack_sync_reg;
	logic       req_meta_reg;
	logic       req_sync_reg;
	logic       ack_reg;

	// link side: idle when the acknowledge has caught up with the request
	assign link_ready = (ack_sync_reg == req_reg);

	// capture a byte and toggle the request
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			req_reg  <= 1'b0;
			hold_reg <= 8'h00;
		end else if (link_valid && link_ready) begin
			req_reg  <= ~req_reg;
			hold_reg <= link_byte;
		end
	end

	// acknowledge back into the link domain
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_meta_reg <= 1'b0;
			ack_sync_reg <= 1'b0;
		end else begin
			ack_meta_reg <= ack_reg;
			ack_sync_reg <= ack_meta_reg;
		end
	end

	// request into the system domain
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			req_meta_reg <= 1'b0;
			req_sync_reg <= 1'b0;
		end else begin
			req_meta_reg <= req_reg;
			req_sync_reg <= req_meta_reg;
		end
	end

	// hold_reg is stable while a request is pending, so it is read directly
	assign rx_valid = (req_sync_reg != ack_reg);
	assign rx_byte  = hold_reg;

	// release the link once the loader takes the byte
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_reg <= 1'b0;
		end else if (rx_valid && rx_take) begin
			ack_reg <= ~ack_reg;
		end
	end
endmodule : bhl_link_rx

// ==== dv/bhl_eeprom_model.sv ====
`timescale 1ns/1ps
// eeprom side of the header link: serves queued bytes one per handshake
module bhl_eeprom_model (
	input  wire logic rst_n,
	input  wire logic link_ready,
	output logic      link_clk,
	output logic      link_valid,
	output logic [7:0] link_byte
);
	logic [7:0] q[$];
	int         tail = 0;
	// link clock runs in reset and while a frame is pending, stands low otherwise
	initial begin
		link_clk = 1'b0;
		forever begin
			#80 link_clk = 1'b1;
			#80 link_clk = 1'b0;
			while (rst_n === 1'b1 && q.size() == 0 && tail == 0 && link_valid === 1'b0) #5;
		end
	end
	// hold byte until taken, then flip the released byte line
	always @(posedge link_clk) begin
		if (rst_n !== 1'b1) begin
			link_valid <= 1'b0;
			link_byte  <= 8'h00;
		end else if (link_valid && link_ready) begin
			link_valid <= 1'b0;
			link_byte  <= ~link_byte;
			tail       <= 8;
		end else if (!link_valid && link_ready && q.size() > 0) begin
			link_valid <= 1'b1;
			link_byte  <= q.pop_front();
		end else if (tail > 0) begin
			tail <= tail - 1;
		end
	end
endmodule : bhl_eeprom_model

// ==== dv/tb.sv ====
`timescale 1ns/1ps
module tb;
	logic        sys_clk, rst_n, link_clk, link_valid, link_ready, host_valid, host_ready;
	logic [7:0]  link_byte, host_byte, desc_rd_data, cfg_max_power, code_data;
	logic        get_dev_desc, dev_desc_ok, cfg_desc_ok, str_desc_ok, cfg_self_powered;
	logic        cfg_remote_wakeup, cfg_bulk_out_ep1, code_wr_en, usb_attach, fw_start;
	logic        fw_running;
	logic [1:0]  desc_rd_sel;
	logic [6:0]  desc_rd_addr;
	logic [15:0] code_addr;
	logic [23:0] wr_q[$];
	int          err_total = 0;
	int          checked = 0;
	int          n_start = 0;
	localparam logic [255:0] DEV = 144'h1201_1001_ff00_0008_3412_7856_0002_0102_0301;
	localparam logic [255:0] CFG = 200'h0902_1900_0101_00e0_6409_0400_0001_ff00_0000_0705_0102_4000_00;
	localparam logic [255:0] STR = 208'h0403_0904_0603_4100_4200_0603_4300_4400_0a03_3100_3200_3300_3400;

	bhl_eeprom_model eep (.rst_n, .link_ready, .link_clk, .link_valid, .link_byte);
	bhl_loader #(.SIGNATURE_LOW_BYTE(8'h5a), .SIGNATURE_HIGH_BYTE(8'ha5), .REATTACH_CYC(20)) DUT (
		.sys_clk, .rst_n, .link_clk, .link_valid, .link_byte, .link_ready, .host_valid,
		.host_byte, .host_ready, .get_dev_desc, .desc_rd_sel, .desc_rd_addr, .desc_rd_data,
		.dev_desc_ok, .cfg_desc_ok, .str_desc_ok, .cfg_self_powered, .cfg_remote_wakeup,
		.cfg_max_power, .cfg_bulk_out_ep1, .code_wr_en, .code_addr, .code_data, .usb_attach,
		.fw_start, .fw_running);

	// system clock
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	// records code writes and start pulses where they are settled
	always @(negedge sys_clk) begin
		if (code_wr_en === 1'b1) wr_q.push_back({code_addr, code_data});
		if (fw_start === 1'b1) n_start++;
	end

	task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : wrap_up
	// reset spans six system cycles, then two link edges, then one more system cycle
	task automatic do_reset();
		@(posedge sys_clk);
		rst_n <= 1'b0;
		repeat (6) @(posedge sys_clk);
		repeat (2) @(posedge link_clk);
		@(posedge sys_clk);
		rst_n <= 1'b1;
		wr_q.delete();
		n_start = 0;
		@(posedge sys_clk);
	endtask : do_reset
	task automatic sig(logic [7:0] lo, logic [7:0] hi);
		eep.q.push_back(lo);
		eep.q.push_back(hi);
	endtask : sig
	// block: type, size low, size high, content sum plus fix, content
	task automatic blk(logic [7:0] ty, logic [255:0] v, int n, logic [7:0] fix);
		logic [7:0] s;
		s = fix;
		for (int i = 0; i < n; i++) s += v[8*(n-1-i) +: 8];
		eep.q.push_back(ty);
		eep.q.push_back(8'(n));
		eep.q.push_back(8'(n >> 8));
		eep.q.push_back(s);
		for (int i = 0; i < n; i++) eep.q.push_back(v[8*(n-1-i) +: 8]);
	endtask : blk
	// a link still busy when the limit runs out counts as a mismatch
	task automatic drain();
		for (int i = 0; i < 60000 && (eep.q.size() > 0 || eep.tail > 0 || link_valid); i++)
			@(posedge sys_clk);
		repeat (20) @(posedge sys_clk);
		chk("link busy", 16'h0000, 16'(eep.q.size()) | {15'h0000, link_valid});
	endtask : drain
	task automatic run_hdr();
		eep.q.push_back(bhl_pkg::TYPE_END);
		drain();
	endtask : run_hdr
	task automatic rd(logic [1:0] sel, logic [6:0] a, logic [7:0] exp);
		desc_rd_sel  <= sel;
		desc_rd_addr <= a;
		repeat (2) @(posedge sys_clk);
		#1 chk("desc_rd_data", exp, desc_rd_data);
		@(posedge sys_clk);
	endtask : rd
	// host request pulse, then bytes offered until each is taken
	task automatic host(logic [39:0] v);
		logic r;
		get_dev_desc <= 1'b1;
		@(posedge sys_clk);
		get_dev_desc <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			host_valid <= 1'b1;
			host_byte  <= v[8*(4-i) +: 8];
			r = 1'b0;
			for (int k = 0; k < 50 && !r; k++) begin
				@(negedge sys_clk);
				r = (host_ready === 1'b1);
				@(posedge sys_clk);
			end
			chk("host_ready", 16'h0001, {15'h0000, r});
		end
		host_valid <= 1'b0;
		repeat (3) @(posedge sys_clk);
	endtask : host
	task automatic chk_fw(logic [31:0] v, int n);
		chk("code writes", 16'(n), 16'(wr_q.size()));
		for (int i = 0; i < n && i < wr_q.size(); i++)
			chk("code write", {8'(i), v[8*(n-1-i) +: 8]}, {wr_q[i][15:8], wr_q[i][7:0]});
		chk("fw_start pulses", 16'h0001, 16'(n_start));
		chk("fw_running", 16'h0001, {15'h0000, fw_running});
	endtask : chk_fw

	task automatic t_desc();
		do_reset();
		sig(8'h5a, 8'ha5);
		blk(bhl_pkg::TYPE_DEV, DEV, 18, 8'h00);
		blk(bhl_pkg::TYPE_CFG, CFG, 25, 8'h00);
		blk(bhl_pkg::TYPE_STR, STR, 26, 8'h00);
		run_hdr();
		chk("oks", 16'h0007, {dev_desc_ok, cfg_desc_ok, str_desc_ok});
		chk("attr", 16'h0003, {cfg_self_powered, cfg_remote_wakeup});
		chk("power", 16'h0064, cfg_max_power);
		chk("bulk ep", 16'h0001, cfg_bulk_out_ep1);
		chk("attach", 16'h0002, {usb_attach, fw_running});
		rd(2'd0, 7'd7, 8'h08);
		rd(2'd0, 7'd17, 8'h01);
		rd(2'd0, 7'd18, 8'h00);
		rd(2'd1, 7'd2, 8'h19);
		rd(2'd1, 7'd20, 8'h01);
		rd(2'd2, 7'd3, 8'h04);
	endtask : t_desc
	task automatic t_host();
		do_reset();
		sig(8'h5a, 8'ha5);
		blk(bhl_pkg::TYPE_DEV, DEV, 18, 8'h01);
		run_hdr();
		chk("dev ok, attach", 16'h0001, {dev_desc_ok, usb_attach});
		chk("idle host", 16'h0000, {host_ready, 8'(wr_q.size())});
		host(40'h02_0000_a1b2);
		chk("detached", 16'h0000, usb_attach);
		repeat (30) @(posedge sys_clk);
		chk("reattached", 16'h0100, {usb_attach, 8'(n_start)});
		wr_q.delete();
		host(40'h02_0053_a1b2);
		chk_fw(32'h0000_a1b2, 2);
	endtask : t_host
	// autoexec with no end marker; a device block first makes the attach early
	task automatic t_auto(bit with_dev);
		do_reset();
		sig(8'h5a, 8'ha5);
		if (with_dev) blk(bhl_pkg::TYPE_DEV, DEV, 18, 8'h00);
		blk(8'h09, 256'h1122, 2, 8'h00);
		blk(8'h09, 256'h0, 0, 8'h00);
		blk(bhl_pkg::TYPE_AUTO, 256'h1122_3344, 4, 8'h00);
		drain();
		chk_fw(32'h1122_3344, 4);
		chk("attach", 16'(with_dev), {15'h0000, usb_attach});
	endtask : t_auto
	task automatic t_badsig();
		do_reset();
		sig(8'ha5, 8'h5a);
		drain();
		chk("bad sig", 16'h0002, {usb_attach, dev_desc_ok});
	endtask : t_badsig

	initial begin
		rst_n = 1'b0;
		host_valid = 1'b0;
		host_byte = 8'h00;
		get_dev_desc = 1'b0;
		desc_rd_sel = 2'd0;
		desc_rd_addr = 7'd0;
		t_desc();
		t_host();
		t_auto(1'b0);
		t_auto(1'b1);
		t_badsig();
		wrap_up();
	end
	// watchdog against a stalled handshake
	initial begin
		#450_000;
		err_total++;
		wrap_up();
	end
endmodule : tb
